// *** rer_pkg.sv ***
// shared constants and types for the runtime error reporter
package rer_pkg;
    // system clock and led flash timing
    localparam int CLK_HZ        = 100_000_000;
    localparam int FLASH_MS      = 250;
    localparam int FLASH_CYC     = CLK_HZ / 1000 * FLASH_MS;
    localparam int TICK_W        = 25;

    // text record and buffer
    localparam int TXT_LEN       = 7;
    localparam int FIFO_DEPTH    = 16;
    localparam int CHAR_W        = 8;
    localparam logic [7:0] CH_E    = 8'h45;
    localparam logic [7:0] CH_V    = 8'h56;
    localparam logic [7:0] CH_DASH = 8'h2d;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [2:0] IDX_E   = 3'h0;
    localparam logic [2:0] IDX_V   = 3'h1;
    localparam logic [2:0] IDX_M10 = 3'h2;
    localparam logic [2:0] IDX_M1  = 3'h3;
    localparam logic [2:0] IDX_DSH = 3'h4;
    localparam logic [2:0] IDX_V10 = 3'h5;
    localparam logic [2:0] IDX_LST = 3'h6;
    localparam logic [6:0] TEN     = 7'h0a;

    // module identifiers
    localparam logic [6:0] MODULE_BUS_COMMS      = 7'h01;
    localparam logic [6:0] MODULE_INTERPRETER    = 7'h03;
    localparam logic [6:0] MODULE_EXTENDED_SERIAL = 7'h17;
    localparam logic [6:0] MODULE_HW_FIRST       = 7'h32;
    localparam logic [6:0] MODULE_ANALOG_OUT     = 7'h37;
    localparam logic [6:0] MODULE_TIME_OF_DAY    = 7'h38;
    localparam logic [6:0] MODULE_GAP_A          = 7'h0b;
    localparam logic [6:0] MODULE_GAP_B          = 7'h14;
    localparam logic [6:0] MODULE_GAP_C          = 7'h16;

    // error values
    localparam logic [6:0] INVALID_INDEX_FAULT          = 7'h01;
    localparam logic [6:0] NO_INIT_FAULT                = 7'h0a;
    localparam logic [6:0] INSUFFICIENT_THROUGHPUT_FAULT = 7'h17;
    localparam logic [6:0] BAD_BAUD_FAULT               = 7'h1e;
    localparam logic [6:0] MAILBOX_RESEND_FAULT         = 7'h22;
    localparam logic [6:0] MAILBOX_XMIT_FAULT           = 7'h23;
    localparam logic [6:0] LIMIT_TYPE_FAULT             = 7'h28;
    localparam logic [6:0] READONLY_WRITE_FAULT         = 7'h2d;
    localparam logic [6:0] POT_TYPE_FAULT               = 7'h32;
    localparam logic [6:0] QUADRATURE_PHASE_FAULT       = 7'h33;

    // shared led code 68 as marker and digit flash counts
    localparam logic [3:0] RED1_FLASHES = 4'h1;
    localparam logic [3:0] YEL1_FLASHES = 4'h6;
    localparam logic [3:0] RED2_FLASHES = 4'h2;
    localparam logic [3:0] YEL2_FLASHES = 4'h8;

    typedef struct packed {
        logic [6:0] module_id;
        logic [6:0] value;
    } rer_fault_t;

    typedef enum logic [2:0] {
        LED_IDLE = 3'b000,
        LED_RED1 = 3'b001,
        LED_YEL1 = 3'b010,
        LED_RED2 = 3'b011,
        LED_YEL2 = 3'b100
    } rer_led_t;
endpackage

// *** rer_reporter.sv ***
// runtime fault latch, text record sender and its fifo, led code flasher
//
// Contract
// - A fault forms a code from the faulting module id and the error value.
// - The module id is held in an output readable by the program.
// - The error value is held in a separate readable output.
// - Every fault sends its code as text on the serial stream unasked.
// - The text is E, V, two module digits, a dash and two value digits.
// - Software module ids are 01 to 23 as listed.
// - Hardware module ids are 50 to 56 as listed.
// - General error values are 01 to 10.
// - Interpreter error values are 11 to 23.
// - Bus mailbox error values are 30 to 35.
// - Error values 40 to 45 cover limit and parameter faults.
// - Pot type fault is 50 and encoder phase fault is 51.
// - Any fault shows on the leds as the one code 68.
// - Leds repeat red marker, yellow six, red second marker, yellow eight.

module rer_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wr_r, wr_nxt, rd_r, rd_nxt;
    logic         full, empty;

    assign empty     = (wr_r == rd_r);
    assign full      = (wr_r[AW-1:0] == rd_r[AW-1:0]) && (wr_r[AW] != rd_r[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_r[AW-1:0]];

    always_comb begin
        wr_nxt = wr_r + (AW+1)'(in_valid && !full);
        rd_nxt = rd_r + (AW+1)'(out_ready && !empty);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
        if (in_valid && !full)
            mem[wr_r[AW-1:0]] <= in_data;
    end

    // a fill while full must not disturb the word waiting at the head
    a_fifo_head_hold: assert property (@(posedge sys_clk) disable iff (reset)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("fifo head changed before it was taken");
    c_fifo_full: cover property (@(posedge sys_clk) disable iff (reset) full);
endmodule // rer_fifo

module rer_reporter
    import rer_pkg::*;
#(
    parameter int FLASH_CYCLES = rer_pkg::FLASH_CYC
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // fault report from the library
    input  wire logic             fault_valid,
    input  wire rer_pkg::rer_fault_t fault_in,
    output logic                  fault_ready,
    // program-readable fault state
    output logic [6:0]            latest_fault_module_id,
    output logic [6:0]            latest_fault_value,
    output logic                  latest_fault_known,
    output logic                  fault_seen,
    // serial text stream
    output logic                  tx_valid,
    input  wire logic             tx_ready,
    output logic [7:0]            tx_data,
    // status leds
    output logic                  led_red,
    output logic                  led_yellow
);
    import rer_pkg::*;

    function automatic logic known_code(input rer_fault_t f);
        logic m_ok;
        logic v_ok;
        m_ok = (f.module_id >= MODULE_BUS_COMMS && f.module_id <= MODULE_EXTENDED_SERIAL
                && f.module_id != MODULE_GAP_A && f.module_id != MODULE_GAP_B
                && f.module_id != MODULE_GAP_C)
            || (f.module_id >= MODULE_HW_FIRST
                && f.module_id <= MODULE_TIME_OF_DAY);
        v_ok = (f.value >= INVALID_INDEX_FAULT
                && f.value <= INSUFFICIENT_THROUGHPUT_FAULT)
            || (f.value >= BAD_BAUD_FAULT && f.value <= MAILBOX_XMIT_FAULT)
            || (f.value >= LIMIT_TYPE_FAULT && f.value <= READONLY_WRITE_FAULT)
            || (f.value == POT_TYPE_FAULT || f.value == QUADRATURE_PHASE_FAULT);
        return m_ok && v_ok;
    endfunction

    function automatic logic [7:0] digit(input logic [6:0] v, input logic tens);
        logic [6:0] d;
        d = tens ? 7'(v / TEN) : 7'(v % TEN);
        return CH_ZERO + {1'b0, d};
    endfunction

    // fault latch and text sequencer
    rer_fault_t latest_r, latest_nxt;
    logic       known_r, known_nxt, seen_r, seen_nxt;
    logic       busy_r, busy_nxt;
    logic [2:0] idx_r, idx_nxt;
    logic       take, push_ready;
    logic [7:0] push_data;

    // one record in flight at a time keeps the text of two faults from interleaving
    assign fault_ready = !busy_r;
    assign take        = fault_valid && !busy_r;

    always_comb begin
        latest_nxt = latest_r;
        known_nxt  = known_r;
        seen_nxt   = seen_r;
        busy_nxt   = busy_r;
        idx_nxt    = idx_r;
        if (take) begin
            latest_nxt = fault_in;
            known_nxt  = known_code(fault_in);
            seen_nxt   = 1'b1;
            busy_nxt   = 1'b1;
            idx_nxt    = IDX_E;
        end else if (busy_r && push_ready) begin
            if (idx_r == IDX_LST)
                busy_nxt = 1'b0;
            else
                idx_nxt = idx_r + 3'h1;
        end
    end

    always_comb begin
        case (idx_r)
            IDX_E:   push_data = CH_E;
            IDX_V:   push_data = CH_V;
            IDX_M10: push_data = digit(latest_r.module_id, 1'b1);
            IDX_M1:  push_data = digit(latest_r.module_id, 1'b0);
            IDX_DSH: push_data = CH_DASH;
            IDX_V10: push_data = digit(latest_r.value, 1'b1);
            default: push_data = digit(latest_r.value, 1'b0);
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            latest_r <= '0;
            known_r  <= 1'b0;
            seen_r   <= 1'b0;
            busy_r   <= 1'b0;
            idx_r    <= IDX_E;
        end else begin
            latest_r <= latest_nxt;
            known_r  <= known_nxt;
            seen_r   <= seen_nxt;
            busy_r   <= busy_nxt;
            idx_r    <= idx_nxt;
        end
    end

    assign latest_fault_module_id = latest_r.module_id;
    assign latest_fault_value     = latest_r.value;
    assign latest_fault_known     = known_r;
    assign fault_seen             = seen_r;

    // a slow terminal stalls the sequencer, which then refuses new faults
    rer_fifo #(.W(CHAR_W), .D(FIFO_DEPTH)) u_fifo (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .in_valid  (busy_r),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

    // led code flasher
    rer_led_t            st_r, st_nxt;
    logic [TICK_W-1:0]   tick_r, tick_nxt;
    logic                on_r, on_nxt;
    logic [3:0]          cnt_r, cnt_nxt, group_len;
    logic                red_r, red_nxt, yel_r, yel_nxt;
    logic                tick_end;

    assign tick_end = (tick_r == TICK_W'(FLASH_CYCLES - 1));

    always_comb begin
        case (st_r)
            LED_RED1: group_len = RED1_FLASHES;
            LED_YEL1: group_len = YEL1_FLASHES;
            LED_RED2: group_len = RED2_FLASHES;
            LED_YEL2: group_len = YEL2_FLASHES;
            default:  group_len = RED1_FLASHES;
        endcase
    end

    always_comb begin
        st_nxt   = st_r;
        tick_nxt = tick_r;
        on_nxt   = on_r;
        cnt_nxt  = cnt_r;
        if (st_r == LED_IDLE) begin
            if (take) begin
                st_nxt   = LED_RED1;
                on_nxt   = 1'b1;
                tick_nxt = '0;
                cnt_nxt  = '0;
            end
        end else if (!tick_end) begin
            tick_nxt = tick_r + TICK_W'(1);
        end else begin
            tick_nxt = '0;
            on_nxt   = !on_r;
            if (!on_r) begin
                on_nxt = 1'b1;
                if (cnt_r + 4'h1 == group_len) begin
                    cnt_nxt = '0;
                    case (st_r)
                        LED_RED1: st_nxt = LED_YEL1;
                        LED_YEL1: st_nxt = LED_RED2;
                        LED_RED2: st_nxt = LED_YEL2;
                        default:  st_nxt = LED_RED1;
                    endcase
                end else begin
                    cnt_nxt = cnt_r + 4'h1;
                end
            end
        end
        red_nxt = on_nxt && (st_nxt == LED_RED1 || st_nxt == LED_RED2);
        yel_nxt = on_nxt && (st_nxt == LED_YEL1 || st_nxt == LED_YEL2);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r   <= LED_IDLE;
            tick_r <= '0;
            on_r   <= 1'b0;
            cnt_r  <= '0;
            red_r  <= 1'b0;
            yel_r  <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            tick_r <= tick_nxt;
            on_r   <= on_nxt;
            cnt_r  <= cnt_nxt;
            red_r  <= red_nxt;
            yel_r  <= yel_nxt;
        end
    end

    assign led_red    = red_r;
    assign led_yellow = yel_r;

    // checks
    a_store_module: assert property (@(posedge sys_clk) disable iff (reset)
        take |=> latest_fault_module_id == $past(fault_in.module_id))
        else $error("module id not latched");
    a_store_value: assert property (@(posedge sys_clk) disable iff (reset)
        take |=> latest_fault_value == $past(fault_in.value))
        else $error("error value not latched");
    a_keep_latest: assert property (@(posedge sys_clk) disable iff (reset)
        !take |=> $stable(latest_r))
        else $error("stored fault changed without a new fault");
    a_text_start: assert property (@(posedge sys_clk) disable iff (reset)
        take |=> busy_r && idx_r == IDX_E && push_data == CH_E)
        else $error("text record did not start");
    a_text_dash: assert property (@(posedge sys_clk) disable iff (reset)
        busy_r && idx_r == IDX_DSH |-> push_data == CH_DASH)
        else $error("dash missing from record");
    a_text_end: assert property (@(posedge sys_clk) disable iff (reset)
        busy_r && push_ready && idx_r == IDX_LST |=> !busy_r)
        else $error("record longer than seven characters");
    a_known_mailbox: assert property (@(posedge sys_clk) disable iff (reset)
        take && fault_in.module_id == MODULE_BUS_COMMS
        && fault_in.value == MAILBOX_RESEND_FAULT |=> latest_fault_known)
        else $error("mailbox fault not recognised");
    a_led_start: assert property (@(posedge sys_clk) disable iff (reset)
        take && st_r == LED_IDLE |=> st_r == LED_RED1 ##1 led_red && !led_yellow)
        else $error("led code did not start with red");
    a_led_order: assert property (@(posedge sys_clk) disable iff (reset)
        st_r == LED_YEL1 && st_nxt != LED_YEL1 |-> st_nxt == LED_RED2
        && cnt_r == YEL1_FLASHES - 4'h1)
        else $error("yellow group of six out of order");
    a_leds_excl: assert property (@(posedge sys_clk) disable iff (reset)
        !(led_red && led_yellow))
        else $error("both leds lit");

    c_fault_taken: cover property (@(posedge sys_clk) disable iff (reset) take);
    c_busy_refuse: cover property (@(posedge sys_clk) disable iff (reset)
        fault_valid && busy_r);
    c_led_yel2: cover property (@(posedge sys_clk) disable iff (reset)
        st_r == LED_YEL2 ##1 st_r == LED_RED1);
endmodule // rer_reporter

// *** rer_terminal.sv ***
// serial display terminal model that takes the text records, promptly or with stalls
module rer_terminal (
    // clock
    input  wire logic       sys_clk,
    // text stream from the reporter
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data,
    // pacing from the bench
    input  wire logic       stall,
    input  wire logic       slow
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] got [$];

    initial tx_ready = 1'b0;

    // slow mode drops ready every other cycle so the fifo sees gaps
    always @(posedge sys_clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
        tx_ready <= !stall && !(slow && tx_ready);
    end
endmodule // rer_terminal

// *** runtime_error_reporter_bench.sv ***
// bench for the runtime error reporter: fault rows, flooding, led pattern, reset
module runtime_error_reporter_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import rer_pkg::*;

    localparam int FC = 4;
    typedef struct {logic [6:0] m; logic [6:0] v; logic k;} rer_row_t;

    logic       sys_clk, reset, fault_valid, fault_ready, tx_valid, tx_ready;
    logic       stall, slow, known, seen, led_red, led_yellow;
    logic [6:0] mod_id, val;
    logic [7:0] tx_data;
    rer_fault_t fault_in;
    int         fails, tests_run, base;
    string      flashes;
    logic       red_d, yel_d;
    rer_row_t   rows [10] = '{'{7'h37, 7'h01, 1'b1}, '{7'h01, 7'h0a, 1'b1},
        '{7'h03, 7'h17, 1'b1}, '{7'h17, 7'h1e, 1'b1}, '{7'h32, 7'h23, 1'b1},
        '{7'h38, 7'h2d, 1'b1}, '{7'h34, 7'h33, 1'b1}, '{7'h33, 7'h32, 1'b1},
        '{7'h0c, 7'h28, 1'b1}, '{7'h0b, 7'h18, 1'b0}};

    rer_reporter #(.FLASH_CYCLES(FC)) u_rer_reporter (
        .sys_clk(sys_clk), .reset(reset), .fault_valid(fault_valid),
        .fault_in(fault_in), .fault_ready(fault_ready),
        .latest_fault_module_id(mod_id), .latest_fault_value(val),
        .latest_fault_known(known), .fault_seen(seen), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .led_red(led_red),
        .led_yellow(led_yellow));

    rer_terminal u_rer_terminal (
        .sys_clk(sys_clk), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .stall(stall), .slow(slow));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // led flash log, sampled away from the launching edge
    always @(negedge sys_clk) begin
        if (reset) flashes = "";
        else if (led_red && !red_d) flashes = {flashes, "r"};
        else if (led_yellow && !yel_d) flashes = {flashes, "y"};
        red_d = led_red;
        yel_d = led_yellow;
    end

    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // ready is comb but only moves after an edge, so the negedge value is the edge value
    task automatic send_fault(input logic [6:0] m, input logic [6:0] v);
        int   n;
        logic r;
        n = 0;
        fault_in = '{module_id: m, value: v};
        fault_valid = 1'b1;
        do begin
            @(negedge sys_clk);
            r = fault_ready;
            @(posedge sys_clk);
            n++;
        end while (!r && n < 300);
        check("fault taken", r, 1'b1);
        #1 fault_valid = 1'b0;
    endtask

    task automatic expect_text(input logic [6:0] m, input logic [6:0] v, input int at);
        string exp;
        int    n;
        exp = $sformatf("EV%02d-%02d", m, v);
        n = 0;
        while (u_rer_terminal.got.size() < at + 7 && n < 400) begin
            tick(1);
            n++;
        end
        for (int j = 0; j < 7; j++) begin
            check("tx_data", u_rer_terminal.got[at + j], exp[j]);
        end
    endtask

    initial begin
        reset = 1'b1;
        fault_valid = 1'b0;
        fault_in = '0;
        stall = 1'b0;
        slow = 1'b0;
        tick(10);
        reset = 1'b0;
        check("fault_ready", fault_ready, 1'b1);
        check("fault_seen", seen, 1'b0);
        check("leds", {led_red, led_yellow}, 2'b00);
        for (int i = 0; i < 10; i++) begin
            base = u_rer_terminal.got.size();
            slow = i[0];
            send_fault(rows[i].m, rows[i].v);
            tick(1);
            check("module id", mod_id, rows[i].m);
            check("value", val, rows[i].v);
            check("known", known, rows[i].k);
            check("fault_seen", seen, 1'b1);
            check("busy", fault_ready, 1'b0);
            if (i == 0) check("led_red", led_red, 1'b1);
            expect_text(rows[i].m, rows[i].v, base);
        end
        tick(200);
        check("led order", flashes.substr(0, 17) == "ryyyyyyrryyyyyyyyr", 1'b1);
        // flood: stalled terminal, fifo fills, a fault offered while busy is refused
        base = u_rer_terminal.got.size();
        stall = 1'b1;
        send_fault(MODULE_ANALOG_OUT, INVALID_INDEX_FAULT);
        // valid is dropped for one edge so it never moves twice in one step
        tick(1);
        fault_in = '{module_id: 7'h0d, value: 7'h0e};
        fault_valid = 1'b1;
        tick(3);
        fault_valid = 1'b0;
        check("refused", mod_id, MODULE_ANALOG_OUT);
        tick(1);
        send_fault(MODULE_TIME_OF_DAY, QUADRATURE_PHASE_FAULT);
        tick(1);
        send_fault(MODULE_EXTENDED_SERIAL, READONLY_WRITE_FAULT);
        tick(30);
        check("stalled", {fault_ready, tx_valid}, 2'b01);
        check("last module", mod_id, MODULE_EXTENDED_SERIAL);
        check("last value", val, READONLY_WRITE_FAULT);
        stall = 1'b0;
        expect_text(MODULE_ANALOG_OUT, INVALID_INDEX_FAULT, base);
        expect_text(MODULE_TIME_OF_DAY, QUADRATURE_PHASE_FAULT, base + 7);
        expect_text(MODULE_EXTENDED_SERIAL, READONLY_WRITE_FAULT, base + 14);
        // second reset while the leds are flashing
        reset = 1'b1;
        tick(2);
        reset = 1'b0;
        check("reset state", {fault_ready, seen, known, tx_valid}, 4'h8);
        check("reset ids", {mod_id, val}, 14'h0000);
        tick(10);
        check("reset leds", {led_red, led_yellow}, 2'b00);
        base = u_rer_terminal.got.size();
        send_fault(MODULE_BUS_COMMS, MAILBOX_RESEND_FAULT);
        tick(2);
        check("restart led", led_red, 1'b1);
        expect_text(MODULE_BUS_COMMS, MAILBOX_RESEND_FAULT, base);
        give_verdict();
    end

    // the whole run needs a few hundred cycles; this is far past that
    initial begin
        #200_000;
        fails++;
        give_verdict();
    end
endmodule // runtime_error_reporter_bench
